/* inc/afm_map.svh */
`ifndef AFM_MAP_SVH
`define AFM_MAP_SVH
// register byte offsets
`define AFM_OFF_MODE_CONTROL 12'h000
`define AFM_OFF_ADDR_CONTROL 12'h004
`define AFM_OFF_CONFIG_CONTROL 12'h008
`define AFM_OFF_CLIP_CONTROL 12'h00c
`define AFM_OFF_MAP 12'h010
`define AFM_OFF_STATUS 12'h014
`define AFM_OFF_LOAD_STATUS 12'h018
`define AFM_OFF_PINS 12'h01c
// mode_control_reg fields
`define AFM_MODE_PAIR_A_LSB 0
`define AFM_MODE_PAIR_B_LSB 2
`define AFM_MODE_STANDBY 4
// map register fields
`define AFM_MAP_COMP_LSB 0
`define AFM_MAP_CLIP_SEL 3
`define AFM_MAP_WARN 4
`define AFM_MAP_SHUT 5
`define AFM_MAP_LOAD 6
`define AFM_MAP_SUPPLY 7
// config_control_reg fields
`define AFM_CFG_PAR_LSB 0
`define AFM_CFG_ADDR_KEEP 2
// clip_control_reg fields
`define AFM_CLIP_CAL 0
// status fields (active low flags)
`define AFM_ST_PUMP 0
`define AFM_ST_LOW 1
`define AFM_ST_HIGH 2
`define AFM_ST_OC 3
`define AFM_ST_WARN 4
`define AFM_ST_SHUT 5
// reset values
`define AFM_RST_MODE 32'h0000_0010
`define AFM_RST_MAP 32'h0000_0000
`define AFM_RST_CFG 32'h0000_0004
`define AFM_RST_CLIP 32'h0000_0000
`define AFM_RST_ADDR 32'h0000_0000
`endif

/* inc/afm_pkg.sv */
package afm_pkg;
	typedef enum logic [1:0] {
		AFM_PAIR_TRISTATE = 2'b00,
		AFM_PAIR_MUTE = 2'b01,
		AFM_PAIR_RSVD = 2'b10,
		AFM_PAIR_PLAY = 2'b11
	} afm_pair_e;
	typedef enum logic [1:0] {
		AFM_PAR_FOUR = 2'b00,
		AFM_PAR_21_A = 2'b01,
		AFM_PAR_21_B = 2'b10,
		AFM_PAR_TWO = 2'b11
	} afm_par_e;
	typedef logic [1:0] afm_addr_t;
	typedef logic [2:0] afm_comp_t;
	typedef logic [3:0] afm_chan_t;
endpackage

/* rtl/afm_fault_seq.sv */
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "afm_map.svh"
// Operation
// - pump flag stays low until hold voltage recovers above release level
// - supply low: outputs tri-stated, flag low, fault line asserted
// - supply high: flag low, fault asserted, standby latched after it ends
// - clip output is open-drain clipping indicator
// - fault line covers high, low supply, thermal warn, shutdown, overcurrent
// - clip pin select makes shared pin mute input or clip output
// - two bits route thermal warning and shutdown onto fault line
// - supply fault route enable routes high, low, overcurrent to fault
// - load route enable sends load results to clip output
// - three-bit compensation field selects integrator capacitor setting
// - two-bit address field picks one of four alternative addresses
// - new address active only after default address keep bit written 0
// - pair mode 00 tri-state, 01 mute, 11 play
// - parallel select picks four-channel, 2.1 or two-channel operation
// - with load routing, clip output is NOR of load bits
// - hold voltage below lower level sets pump flag and tri-states
module afm_fault_seq (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RESET,
	// axi4-lite write address
	input wire logic [11:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	// axi4-lite write data
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	// axi4-lite write response
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// axi4-lite read
	input wire logic [11:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// analog monitor comparators (asynchronous)
	input wire logic HOLD_BELOW_LOW,
	input wire logic HOLD_ABOVE_RELEASE,
	input wire logic SUPPLY_LOW,
	input wire logic SUPPLY_HIGH,
	input wire logic OVERCURRENT,
	input wire logic THERMAL_WARN,
	input wire logic THERMAL_SHUTDOWN,
	input wire logic [3:0] CLIP_DETECT,
	input wire logic [3:0] LOAD_DETECT,
	// pins
	input wire logic ENABLE_PIN,
	input wire logic MUTE_OR_CLIP_PIN_IN,
	output logic MUTE_OR_CLIP_PIN_OUT,
	output logic MUTE_OR_CLIP_PIN_OE_N,
	output logic CLIP_OUT_N_OUT,
	output logic CLIP_OUT_N_OE_N,
	output logic FAULT_OUT_N_OUT,
	output logic FAULT_OUT_N_OE_N,
	// amplifier control
	output logic [1:0] PAIR_A_MODE,
	output logic [1:0] PAIR_B_MODE,
	output logic OUTPUTS_TRISTATE,
	output logic STANDBY,
	output logic MUTE_REQUEST,
	output logic [3:0] PARALLEL_CONFIG,
	output logic [2:0] COMP_SELECT,
	output logic [1:0] BUS_ADDRESS
);
	import afm_pkg::*;

	logic [10:0] sync1_reg;
	logic [10:0] sync2_reg;
	logic [7:0] load_s1_reg;
	logic [7:0] load_s2_reg;
	logic en_s1_reg;
	logic en_s2_reg;
	logic en_prev_reg;
	logic mp_s1_reg;
	logic mp_s2_reg;
	logic [31:0] mode_control_reg;
	logic [31:0] addr_control_reg;
	logic [31:0] config_control_reg;
	logic [31:0] clip_control_reg;
	logic [31:0] map_reg;
	logic pump_undervolt_flag;
	logic high_latched_reg;
	logic strap_reg;
	logic aw_got_reg;
	logic w_got_reg;
	logic [11:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic [5:0] status_flags;
	logic [31:0] rd_next;
	logic rd_ok;
	logic wr_go;
	logic wr_ok;
	logic fault_next;
	logic clip_next;
	logic [3:0] clip_s;
	logic [3:0] load_s;
	logic hold_low_s;
	logic hold_rel_s;
	logic sup_low_s;
	logic sup_high_s;
	logic oc_s;
	logic warn_s;
	logic shut_s;
	logic clip_sel;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [3:0] par_map(input afm_par_e p);
		unique case (p)
			AFM_PAR_FOUR: par_map = 4'h0;
			AFM_PAR_21_A: par_map = 4'h1;
			AFM_PAR_21_B: par_map = 4'h2;
			AFM_PAR_TWO: par_map = 4'h3;
		endcase
	endfunction

	// two-stage synchronisers
	always_ff @(posedge CORE_CLK) begin
		sync1_reg <= {SUPPLY_LOW, SUPPLY_HIGH, OVERCURRENT, THERMAL_WARN,
			THERMAL_SHUTDOWN, HOLD_BELOW_LOW, HOLD_ABOVE_RELEASE,
			ENABLE_PIN, MUTE_OR_CLIP_PIN_IN, 2'b00};
		sync2_reg <= sync1_reg;
		load_s1_reg <= {CLIP_DETECT, LOAD_DETECT};
		load_s2_reg <= load_s1_reg;
	end
	assign {sup_low_s, sup_high_s, oc_s, warn_s, shut_s, hold_low_s,
		hold_rel_s} = sync2_reg[10:4];
	assign clip_s = load_s2_reg[7:4];
	assign load_s = load_s2_reg[3:0];
	always_ff @(posedge CORE_CLK) begin
		en_s1_reg <= sync2_reg[3];
		mp_s1_reg <= sync2_reg[2];
	end
	assign en_s2_reg = en_s1_reg;
	assign mp_s2_reg = mp_s1_reg;

	// address strap caught on enable rising
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			en_prev_reg <= 1'b0;
			strap_reg <= 1'b0;
		end else begin
			en_prev_reg <= en_s2_reg;
			if (en_s2_reg && !en_prev_reg) begin
				strap_reg <= mp_s2_reg;
			end
		end
	end

	// charge pump undervoltage flag with hysteresis
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			pump_undervolt_flag <= 1'b0;
		end else if (hold_low_s) begin
			pump_undervolt_flag <= 1'b1;
		end else if (hold_rel_s) begin
			pump_undervolt_flag <= 1'b0;
		end
	end

	// active-low status word
	assign status_flags[`AFM_ST_PUMP] = !pump_undervolt_flag;
	assign status_flags[`AFM_ST_LOW] = !sup_low_s;
	assign status_flags[`AFM_ST_HIGH] = !sup_high_s;
	assign status_flags[`AFM_ST_OC] = !oc_s;
	assign status_flags[`AFM_ST_WARN] = !warn_s;
	assign status_flags[`AFM_ST_SHUT] = !shut_s;

	// axi4-lite write path
	assign wr_go = aw_got_reg && w_got_reg && !BVALID;
	always_comb begin
		unique case (aw_addr_reg)
			`AFM_OFF_MODE_CONTROL, `AFM_OFF_ADDR_CONTROL,
			`AFM_OFF_CONFIG_CONTROL, `AFM_OFF_CLIP_CONTROL,
			`AFM_OFF_MAP: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			AWREADY <= 1'b0;
			WREADY <= 1'b0;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_addr_reg <= 12'h000;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			BVALID <= 1'b0;
			BRESP <= 2'b00;
		end else begin
			AWREADY <= !aw_got_reg && !AWREADY && AWVALID;
			WREADY <= !w_got_reg && !WREADY && WVALID;
			if (AWVALID && AWREADY) begin
				aw_got_reg <= 1'b1;
				aw_addr_reg <= {AWADDR[11:2], 2'b00};
			end
			if (WVALID && WREADY) begin
				w_got_reg <= 1'b1;
				w_data_reg <= WDATA;
				w_strb_reg <= WSTRB;
			end
			if (wr_go) begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				BVALID <= 1'b1;
				BRESP <= wr_ok ? 2'b00 : 2'b10;
			end else if (BVALID && BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	// control registers
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			mode_control_reg <= `AFM_RST_MODE;
			addr_control_reg <= `AFM_RST_ADDR;
			config_control_reg <= `AFM_RST_CFG;
			clip_control_reg <= `AFM_RST_CLIP;
			map_reg <= `AFM_RST_MAP;
		end else begin
			if (wr_go && aw_addr_reg == `AFM_OFF_MODE_CONTROL) begin
				mode_control_reg <= merge(mode_control_reg, w_data_reg,
					w_strb_reg) & 32'h0000_001f;
			end
			if (sup_high_s) begin
				mode_control_reg[`AFM_MODE_STANDBY] <= 1'b1;
			end
			if (wr_go && aw_addr_reg == `AFM_OFF_ADDR_CONTROL) begin
				addr_control_reg <= merge(addr_control_reg, w_data_reg,
					w_strb_reg) & 32'h0000_0003;
			end
			if (wr_go && aw_addr_reg == `AFM_OFF_CONFIG_CONTROL) begin
				config_control_reg <= merge(config_control_reg,
					w_data_reg, w_strb_reg) & 32'h0000_0007;
			end
			if (wr_go && aw_addr_reg == `AFM_OFF_CLIP_CONTROL) begin
				clip_control_reg <= merge(clip_control_reg, w_data_reg,
					w_strb_reg) & 32'h0000_0001;
			end
			if (wr_go && aw_addr_reg == `AFM_OFF_MAP) begin
				map_reg <= merge(map_reg, w_data_reg, w_strb_reg) &
					32'h0000_00ff;
			end
		end
	end

	// axi4-lite read path
	always_comb begin
		rd_ok = 1'b1;
		unique case ({ARADDR[11:2], 2'b00})
			`AFM_OFF_MODE_CONTROL: rd_next = mode_control_reg;
			`AFM_OFF_ADDR_CONTROL: rd_next = addr_control_reg;
			`AFM_OFF_CONFIG_CONTROL: rd_next = config_control_reg;
			`AFM_OFF_CLIP_CONTROL: rd_next = clip_control_reg;
			`AFM_OFF_MAP: rd_next = map_reg;
			`AFM_OFF_STATUS: rd_next = {26'h0, status_flags};
			`AFM_OFF_LOAD_STATUS: rd_next = {24'h0, clip_s, load_s};
			`AFM_OFF_PINS: rd_next = {29'h0, strap_reg, en_s2_reg,
				high_latched_reg};
			default: begin
				rd_next = 32'h0000_0000;
				rd_ok = 1'b0;
			end
		endcase
	end
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			ARREADY <= 1'b0;
			RVALID <= 1'b0;
			RDATA <= 32'h0000_0000;
			RRESP <= 2'b00;
		end else begin
			ARREADY <= ARVALID && !ARREADY && !RVALID;
			if (ARVALID && ARREADY) begin
				RVALID <= 1'b1;
				RDATA <= rd_next;
				RRESP <= rd_ok ? 2'b00 : 2'b10;
			end else if (RVALID && RREADY) begin
				RVALID <= 1'b0;
			end
		end
	end

	// overvoltage seen since last standby clear
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			high_latched_reg <= 1'b0;
		end else if (sup_high_s) begin
			high_latched_reg <= 1'b1;
		end else if (!mode_control_reg[`AFM_MODE_STANDBY]) begin
			high_latched_reg <= 1'b0;
		end
	end

	// fault and clip line composition
	assign clip_sel = map_reg[`AFM_MAP_CLIP_SEL];
	always_comb begin
		fault_next = (map_reg[`AFM_MAP_SUPPLY] &&
			(sup_high_s || sup_low_s || oc_s)) ||
			(map_reg[`AFM_MAP_WARN] && warn_s) ||
			(map_reg[`AFM_MAP_SHUT] && shut_s);
		if (map_reg[`AFM_MAP_LOAD]) begin
			clip_next = |load_s;
		end else begin
			clip_next = |clip_s;
		end
	end

	// pin and control outputs
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			FAULT_OUT_N_OUT <= 1'b0;
			FAULT_OUT_N_OE_N <= 1'b1;
			CLIP_OUT_N_OUT <= 1'b0;
			CLIP_OUT_N_OE_N <= 1'b1;
			MUTE_OR_CLIP_PIN_OUT <= 1'b0;
			MUTE_OR_CLIP_PIN_OE_N <= 1'b1;
			MUTE_REQUEST <= 1'b0;
			PAIR_A_MODE <= AFM_PAIR_TRISTATE;
			PAIR_B_MODE <= AFM_PAIR_TRISTATE;
			OUTPUTS_TRISTATE <= 1'b1;
			STANDBY <= 1'b1;
			PARALLEL_CONFIG <= 4'h0;
			COMP_SELECT <= 3'h0;
			BUS_ADDRESS <= 2'h0;
		end else begin
			FAULT_OUT_N_OE_N <= !fault_next;
			CLIP_OUT_N_OE_N <= !(clip_next && !(map_reg[`AFM_MAP_LOAD] &&
				1'b0));
			MUTE_OR_CLIP_PIN_OE_N <= !(clip_sel && |clip_s);
			MUTE_REQUEST <= !clip_sel && !mp_s2_reg;
			PAIR_A_MODE <= mode_control_reg[`AFM_MODE_PAIR_A_LSB +: 2];
			PAIR_B_MODE <= mode_control_reg[`AFM_MODE_PAIR_B_LSB +: 2];
			OUTPUTS_TRISTATE <= sup_low_s || pump_undervolt_flag ||
				shut_s || mode_control_reg[`AFM_MODE_STANDBY] ||
				!en_s2_reg;
			STANDBY <= mode_control_reg[`AFM_MODE_STANDBY] || !en_s2_reg;
			PARALLEL_CONFIG <= par_map(afm_par_e'(
				config_control_reg[`AFM_CFG_PAR_LSB +: 2]));
			COMP_SELECT <= map_reg[`AFM_MAP_COMP_LSB +: 3];
			if (config_control_reg[`AFM_CFG_ADDR_KEEP]) begin
				BUS_ADDRESS <= {1'b0, strap_reg};
			end else begin
				BUS_ADDRESS <= addr_control_reg[1:0];
			end
		end
	end
endmodule

/* dv/afm_pins.sv */
`timescale 1ns/10ps
// open-drain pins resolved with pull-ups
module afm_pins (
	// device pin enables
	input wire logic flt_oe_n,
	input wire logic clp_oe_n,
	input wire logic mcp_oe_n,
	// host pulls shared pin low for strap or mute
	input wire logic host_pull,
	// resolved pin levels
	output logic flt_n,
	output logic clp_n,
	output logic mcp
);
	assign flt_n = flt_oe_n;
	assign clp_n = clp_oe_n;
	assign mcp = mcp_oe_n & ~host_pull;
endmodule

/* dv/afm_fault_seq_asserts.sv */
`timescale 1ns/10ps
module afm_chk (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RESET,
	// bus activity
	input wire logic AWVALID,
	input wire logic WVALID,
	// monitors
	input wire logic HOLD_BELOW_LOW,
	input wire logic SUPPLY_LOW,
	input wire logic SUPPLY_HIGH,
	input wire logic OVERCURRENT,
	input wire logic THERMAL_WARN,
	input wire logic THERMAL_SHUTDOWN,
	input wire logic [3:0] CLIP_DETECT,
	input wire logic [3:0] LOAD_DETECT,
	// pins and control
	input wire logic MUTE_OR_CLIP_PIN_OUT,
	input wire logic MUTE_OR_CLIP_PIN_OE_N,
	input wire logic CLIP_OUT_N_OUT,
	input wire logic CLIP_OUT_N_OE_N,
	input wire logic FAULT_OUT_N_OUT,
	input wire logic FAULT_OUT_N_OE_N,
	input wire logic OUTPUTS_TRISTATE,
	input wire logic STANDBY,
	input wire logic MUTE_REQUEST
);
	logic w_busy;
	logic no_flt;
	assign w_busy = AWVALID | WVALID;
	assign no_flt = !(SUPPLY_LOW | SUPPLY_HIGH | OVERCURRENT | THERMAL_WARN
		| THERMAL_SHUTDOWN);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RESET);
	chk_low_tristate: assert property (SUPPLY_LOW [*6] |-> OUTPUTS_TRISTATE)
		else $error("supply low left outputs on");
	chk_pump_tristate: assert property (HOLD_BELOW_LOW [*6] |-> OUTPUTS_TRISTATE)
		else $error("pump low left outputs on");
	chk_high_standby: assert property (SUPPLY_HIGH [*6] |-> STANDBY)
		else $error("overvoltage without standby");
	chk_standby_held: assert property (STANDBY && !w_busy && !$past(w_busy)
		&& !$past(w_busy, 2) |=> STANDBY) else $error("standby left without write");
	chk_fault_release: assert property (no_flt [*6] |-> FAULT_OUT_N_OE_N)
		else $error("fault line low with no source");
	chk_clip_release: assert property ((CLIP_DETECT == 4'h0
		&& LOAD_DETECT == 4'h0) [*6] |-> CLIP_OUT_N_OE_N) else $error("clip low idle");
	chk_od_zero: assert property (!FAULT_OUT_N_OUT && !CLIP_OUT_N_OUT
		&& !MUTE_OR_CLIP_PIN_OUT) else $error("open-drain pin driven high");
	chk_mute_input: assert property (MUTE_REQUEST |-> MUTE_OR_CLIP_PIN_OE_N)
		else $error("shared pin driven while mute input");
endmodule
bind afm_fault_seq afm_chk i_afm_chk (.CORE_CLK, .RESET, .AWVALID, .WVALID,
	.HOLD_BELOW_LOW, .SUPPLY_LOW, .SUPPLY_HIGH, .OVERCURRENT, .THERMAL_WARN,
	.THERMAL_SHUTDOWN, .CLIP_DETECT, .LOAD_DETECT, .MUTE_OR_CLIP_PIN_OUT,
	.MUTE_OR_CLIP_PIN_OE_N, .CLIP_OUT_N_OUT, .CLIP_OUT_N_OE_N, .FAULT_OUT_N_OUT,
	.FAULT_OUT_N_OE_N, .OUTPUTS_TRISTATE, .STANDBY, .MUTE_REQUEST);

/* dv/tb.sv */
`timescale 1ns/10ps
module tb;
	import afm_pkg::*;
	logic CORE_CLK, RESET, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
	logic ARVALID, ARREADY, RVALID, RREADY, hb, ha, en, pull, mcp, flt_n, clp_n;
	logic MUTE_REQUEST, OUTPUTS_TRISTATE, STANDBY, MUTE_OR_CLIP_PIN_OE_N;
	logic CLIP_OUT_N_OE_N, FAULT_OUT_N_OE_N;
	logic [11:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA;
	logic [1:0] BRESP, RRESP, PAIR_A_MODE, PAIR_B_MODE, BUS_ADDRESS;
	logic [2:0] COMP_SELECT;
	logic [3:0] PARALLEL_CONFIG;
	logic [3:0] clipd, loadd;
	logic [4:0] flt;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int mismatches, checks_done, c;
	afm_pair_e m[3] = '{AFM_PAIR_TRISTATE, AFM_PAIR_MUTE, AFM_PAIR_PLAY};
	afm_fault_seq i_afm_fault_seq (
		.CORE_CLK, .RESET, .AWADDR, .AWVALID, .AWREADY, .WDATA,
		.WSTRB(4'hf), .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
		.ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
		.HOLD_BELOW_LOW(hb), .HOLD_ABOVE_RELEASE(ha),
		.SUPPLY_LOW(flt[0]), .SUPPLY_HIGH(flt[1]), .OVERCURRENT(flt[2]),
		.THERMAL_WARN(flt[3]), .THERMAL_SHUTDOWN(flt[4]),
		.CLIP_DETECT(clipd), .LOAD_DETECT(loadd), .ENABLE_PIN(en),
		.MUTE_OR_CLIP_PIN_IN(mcp), .MUTE_OR_CLIP_PIN_OUT(),
		.MUTE_OR_CLIP_PIN_OE_N, .CLIP_OUT_N_OUT(), .CLIP_OUT_N_OE_N,
		.FAULT_OUT_N_OUT(), .FAULT_OUT_N_OE_N, .PAIR_A_MODE, .PAIR_B_MODE,
		.OUTPUTS_TRISTATE, .STANDBY, .MUTE_REQUEST, .PARALLEL_CONFIG,
		.COMP_SELECT, .BUS_ADDRESS);
	afm_pins i_afm_pins (.flt_oe_n(FAULT_OUT_N_OE_N), .clp_oe_n(CLIP_OUT_N_OE_N),
		.mcp_oe_n(MUTE_OR_CLIP_PIN_OE_N), .host_pull(pull), .flt_n, .clp_n, .mcp);
	always #10 CORE_CLK = ~CORE_CLK;
	task automatic cmp(input string n, input logic [33:0] s, input logic [33:0] e);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("FAIL %s exp %h seen %h", n, e, s);
		end
	endtask
	task complete_run;
		if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic w6;
		repeat (6) @(posedge CORE_CLK);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		bq.push_back(r);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		fork
			begin do @(posedge CORE_CLK); while (!AWREADY); AWVALID <= 1'b0; end
			begin do @(posedge CORE_CLK); while (!WREADY); WVALID <= 1'b0; end
		join
		do @(posedge CORE_CLK); while (!BVALID);
		BREADY <= 1'b0;
		@(posedge CORE_CLK);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		rq.push_back({r, d});
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do @(posedge CORE_CLK); while (!ARREADY);
		ARVALID <= 1'b0;
		do @(posedge CORE_CLK); while (!RVALID);
		RREADY <= 1'b0;
		@(posedge CORE_CLK);
	endtask
	always @(posedge CORE_CLK) begin
		if (RVALID && RREADY) cmp("rd", {RRESP, RDATA}, rq.pop_front());
		if (BVALID && BREADY) cmp("wr", 34'(BRESP), 34'(bq.pop_front()));
	end
	initial begin
		repeat (5000) @(posedge CORE_CLK);
		mismatches++;
		complete_run();
	end
	initial begin
		c = $urandom(95);
		{CORE_CLK, AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
		{AWADDR, ARADDR, WDATA, flt, hb, en, pull, clipd, loadd} = '0;
		ha = 1'b1;
		RESET = 1'b1;
		repeat (10) @(posedge CORE_CLK);
		RESET <= 1'b0;
		pull <= 1'b1;
		w6();
		en <= 1'b1;
		w6();
		pull <= 1'b0;
		rd(12'h000, 32'h10, 2'b00);
		rd(12'h008, 32'h4, 2'b00);
		rd(12'h014, 32'h3f, 2'b00);
		rd(12'h100, 32'h0, 2'b10);
		wr(12'h014, 32'h0, 2'b10);
		wr(12'h004, 32'h3, 2'b00);
		w6();
		cmp("addr", 34'(BUS_ADDRESS), 34'h0);
		for (int i = 3; i >= 0; i--) begin
			wr(12'h008, 32'(i), 2'b00);
			rd(12'h008, 32'(i), 2'b00);
			cmp("par", 34'(PARALLEL_CONFIG), 34'(i));
		end
		w6();
		cmp("addr", 34'(BUS_ADDRESS), 34'h3);
		c = $urandom & 7;
		wr(12'h010, 32'(c), 2'b00);
		w6();
		cmp("comp", 34'(COMP_SELECT), 34'(c));
		wr(12'h00c, 32'h1, 2'b00);
		rd(12'h00c, 32'h1, 2'b00);
		foreach (m[i]) begin
			wr(12'h000, {28'h0, m[i], m[i]}, 2'b00);
			w6();
			cmp("pair_a", 34'(PAIR_A_MODE), 34'(m[i]));
			cmp("pair_b", 34'(PAIR_B_MODE), 34'(m[i]));
		end
		wr(12'h00c, 32'h0, 2'b00);
		rd(12'h00c, 32'h0, 2'b00);
		cmp("tri", 34'(OUTPUTS_TRISTATE), 34'h0);
		hb <= 1'b1;
		w6();
		cmp("tri", 34'(OUTPUTS_TRISTATE), 34'h1);
		hb <= 1'b0;
		ha <= 1'b0;
		w6();
		rd(12'h014, 32'h3e, 2'b00);
		ha <= 1'b1;
		w6();
		rd(12'h014, 32'h3f, 2'b00);
		wr(12'h010, 32'hb0, 2'b00);
		for (int i = 0; i < 5; i++) begin
			flt <= 5'(1 << i);
			w6();
			cmp("fault", 34'(flt_n), 34'h0);
			if (i == 0) cmp("tri", 34'(OUTPUTS_TRISTATE), 34'h1);
			rd(12'h014, 32'h3f & ~(32'h2 << i), 2'b00);
			flt <= 5'h0;
			w6();
			cmp("fault", 34'(flt_n), 34'h1);
		end
		cmp("standby_bit", 34'(STANDBY), 34'h1);
		rd(12'h000, 32'h1f, 2'b00);
		wr(12'h000, 32'hf, 2'b00);
		w6();
		cmp("standby_bit", 34'(STANDBY), 34'h0);
		wr(12'h010, 32'h0, 2'b00);
		for (int i = 3; i < 5; i++) begin
			flt <= 5'(1 << i);
			w6();
			cmp("fault", 34'(flt_n), 34'h1);
		end
		flt <= 5'h0;
		wr(12'h000, 32'h5, 2'b00);
		wr(12'h000, 32'h0, 2'b00);
		wr(12'h010, 32'h40, 2'b00);
		loadd <= 4'($urandom_range(15, 1));
		w6();
		cmp("clip", 34'(clp_n), 34'h0);
		loadd <= 4'h0;
		clipd <= 4'hf;
		w6();
		cmp("clip", 34'(clp_n), 34'h1);
		wr(12'h010, 32'h08, 2'b00);
		w6();
		cmp("clip", 34'(clp_n), 34'h0);
		cmp("shared", 34'(mcp), 34'h0);
		clipd <= 4'h0;
		wr(12'h010, 32'h0, 2'b00);
		pull <= 1'b1;
		w6();
		cmp("mute", 34'(MUTE_REQUEST), 34'h1);
		pull <= 1'b0;
		wr(12'h000, 32'h5, 2'b00);
		wr(12'h000, 32'h0, 2'b00);
		wr(12'h000, 32'h10, 2'b00);
		en <= 1'b0;
		w6();
		cmp("standby_bit", 34'(STANDBY), 34'h1);
		cmp("tri", 34'(OUTPUTS_TRISTATE), 34'h1);
		complete_run();
	end
endmodule
